// *** common/irqv_pkg.sv ***
package irqv_pkg;

  typedef logic [7:0] irqv_byte_t;
  typedef logic [15:0] irqv_word_t;
  typedef logic [1:0] irqv_sel_t;

  // ----------------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------------
  localparam irqv_byte_t MVC_IO_OFFSET = 8'h35;
  localparam irqv_byte_t DS_BIAS = 8'h20;
  localparam irqv_byte_t MVC_DS_OFFSET = 8'(MVC_IO_OFFSET + DS_BIAS);
  localparam irqv_byte_t MVC_RESET = 8'h00;
  localparam int BIT_SELECT = 1;
  localparam int BIT_UNLOCK = 0;

  // ----------------------------------------------------------------------
  // Timing and vector placement
  // ----------------------------------------------------------------------
  localparam logic [2:0] UNLOCK_CYCLES = 3'h4;
  localparam irqv_word_t VECTOR_BASE_APP = 16'h0000;
  // Boot start word address per boot-size fuse setting; plain defaults.
  localparam logic [3:0][15:0] BOOT_START_DEF = {16'hF000, 16'hF000, 16'hF000, 16'hF000};
  // Start-up time in clock cycles per start-up fuse setting; plain defaults.
  localparam logic [3:0][15:0] STARTUP_CYC_DEF = {16'h0400, 16'h0100, 16'h0040, 16'h0010};

  // ----------------------------------------------------------------------
  // External interrupt sensing
  // ----------------------------------------------------------------------
  localparam irqv_sel_t SENSE_LOW = 2'h0;
  localparam irqv_sel_t SENSE_FALL = 2'h2;
  localparam irqv_sel_t SENSE_RISE = 2'h3;
  localparam int EDGE_ASYNC_PINS = 4;
  localparam irqv_sel_t WAKE_SAMPLES = 2'h2;
  localparam irqv_byte_t PIN_IDLE = 8'hFF;

  typedef enum logic [1:0] {PD_AWAKE, PD_ASLEEP, PD_STARTUP} irqv_pd_e;

endpackage

// *** common/irqv_sense_if.sv ***
`timescale 1ns/1ps
interface irqv_sense_if;
  logic [15:0] sense_cfg;
  logic [7:0] enable;
  logic io_clk_run;
  logic powerdown;
  logic level_mask;
  logic wdt_tick;
  logic [7:0] req;
  logic wake;

  modport ctrl (output sense_cfg, enable, io_clk_run, powerdown, level_mask, wdt_tick,
                input req, wake);
  modport sense (input sense_cfg, enable, io_clk_run, powerdown, level_mask, wdt_tick,
                 output req, wake);
endinterface

// *** hdl/irqv_ext_sense.sv ***
`timescale 1ns/1ps
module irqv_ext_sense (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  input wire irqv_pkg::irqv_byte_t pins_in,
  irqv_sense_if.sense sense
);
  import irqv_pkg::*;

  typedef struct packed {
    irqv_byte_t sync1;
    irqv_byte_t sync2;
    irqv_byte_t prev;
    irqv_byte_t req;
    logic [7:0][1:0] qual;
    logic wake;
  } irqv_sense_s;

  irqv_sense_s s;
  irqv_sense_s next_s;

  // ----------------------------------------------------------------------
  // Pin sensing
  // ----------------------------------------------------------------------
  always_comb begin
    irqv_sel_t mode;
    logic edge_ok;
    logic low;
    logic hit;
    mode = SENSE_LOW;
    edge_ok = 1'b0;
    low = 1'b0;
    hit = 1'b0;
    next_s = s;
    // Pins are read whatever their direction, so driving them raises requests.
    next_s.sync1 = pins_in; // RULE_09
    next_s.sync2 = s.sync1;
    next_s.wake = 1'b0;
    for (int i = 0; i < 8; i++) begin
      mode = sense.sense_cfg[2*i +: 2]; // RULE_10
      // Upper pins see edges only while the I/O clock runs.
      edge_ok = (i < EDGE_ASYNC_PINS) || sense.io_clk_run; // RULE_12
      low = !s.sync2[i];
      if (edge_ok) begin
        next_s.prev[i] = s.sync2[i];
      end
      case (mode)
        SENSE_LOW: hit = low && !sense.level_mask; // RULE_11
        SENSE_FALL: hit = edge_ok && s.prev[i] && low;
        SENSE_RISE: hit = edge_ok && !s.prev[i] && !low;
        default: hit = 1'b0;
      endcase
      next_s.req[i] = sense.enable[i] && hit;
      // Power-down level wake needs the level on consecutive watchdog samples.
      if (sense.powerdown && sense.enable[i] && (mode == SENSE_LOW)) begin // RULE_14
        if (sense.wdt_tick) begin
          if (!low) begin
            next_s.qual[i] = 2'h0;
          end else if (s.qual[i] != WAKE_SAMPLES) begin
            next_s.qual[i] = 2'(s.qual[i] + 2'h1);
          end
        end
      end else begin
        next_s.qual[i] = 2'h0;
      end
      next_s.wake = next_s.wake || next_s.req[i] || (next_s.qual[i] == WAKE_SAMPLES);
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      s <= '0;
      s.sync1 <= PIN_IDLE;
      s.sync2 <= PIN_IDLE;
      s.prev <= PIN_IDLE;
    end else if (ce_in) begin
      s <= next_s;
    end
  end

  assign sense.req = s.req;
  assign sense.wake = s.wake;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in || !ce_in);

  sequence pd_low_tick;
    sense.powerdown && sense.enable[0] && (sense.sense_cfg[1:0] == SENSE_LOW) &&
      sense.wdt_tick && !s.sync2[0];
  endsequence

  AST_LEVEL_HOLDS: assert property (sense.enable[0] && (sense.sense_cfg[1:0] == SENSE_LOW) && // RULE_11
    !s.sync2[0] && !sense.level_mask |=> s.req[0])
    else $error("level request missing while pin low");
  AST_UPPER_EDGE_GATED: assert property (!sense.io_clk_run && // RULE_12
    (sense.sense_cfg[9:8] != SENSE_LOW) |=> !s.req[4])
    else $error("upper edge seen without io clock");
  AST_LOWER_EDGE_ASYNC: assert property (sense.enable[0] && // RULE_12
    (sense.sense_cfg[1:0] == SENSE_FALL) && s.prev[0] && !s.sync2[0] |=> s.req[0])
    else $error("lower falling edge lost");
  AST_WAKE_SECOND_SAMPLE: assert property ((s.qual[0] == 2'h1) ##0 pd_low_tick // RULE_14
    |=> s.wake)
    else $error("no wake after two low samples");
endmodule

// *** hdl/irqv_ctrl.sv ***
`timescale 1ns/1ps
// Summary of operation
// RULE_01 - The control register answers at I/O offset 0x35 and at data address 0x55.
// RULE_02 - Select bit 1 clear puts vectors at flash start, set puts them at boot start.
// RULE_03 - The relocated vector base is the boot start picked by the boot-size fuses.
// RULE_04 - Software writes unlock first, then the select value with unlock zero within four.
// RULE_05 - Interrupts are held off from unlock until after the next instruction, or four cycles.
// RULE_06 - Holding interrupts off never alters the global interrupt enable flag.
// RULE_07 - Unlock bit 0 clears four cycles after being set, or at once on a select write.
// RULE_08 - Boot lock bits block interrupts when running from the section without the vectors.
// RULE_09 - Enabled external pins raise requests even when driven as outputs.
// RULE_10 - Each pin senses falling edge, rising edge or low level, set per pin in two groups.
// RULE_11 - A low-level pin keeps requesting for as long as it stays low.
// RULE_12 - Upper pin edges need the I/O clock; levels and lower edges work without it.
// RULE_13 - The I/O clock stops in all sleep modes except idle.
// RULE_14 - Power-down level wake samples the level twice on the watchdog tick.
// RULE_15 - A level gone before start-up ends still wakes but raises no level request.
// RULE_16 - A select write without a live unlock leaves the select bit unchanged.
module irqv_ctrl #(
  parameter logic [3:0][15:0] BOOT_START = irqv_pkg::BOOT_START_DEF,
  parameter logic [3:0][15:0] STARTUP_CYC = irqv_pkg::STARTUP_CYC_DEF
) (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  input wire logic io_space_in,
  input wire irqv_pkg::irqv_byte_t addr_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire irqv_pkg::irqv_byte_t wdata_in,
  input wire logic insn_end_in,
  input wire irqv_pkg::irqv_sel_t boot_size_fuses_in,
  input wire logic exec_in_boot_in,
  input wire logic app_side_boot_lock_in,
  input wire logic boot_side_boot_lock_in,
  input wire logic sleep_in,
  input wire logic sleep_idle_in,
  input wire logic sleep_powerdown_in,
  input wire irqv_pkg::irqv_sel_t startup_time_fuses_in,
  input wire logic wdt_tick_in,
  input wire irqv_pkg::irqv_byte_t ext_irq_pins_in,
  input wire irqv_pkg::irqv_byte_t ext_irq_sense_low_in,
  input wire irqv_pkg::irqv_byte_t ext_irq_sense_high_in,
  input wire irqv_pkg::irqv_byte_t ext_irq_enable_in,
  output logic [7:0] rdata_out,
  output logic [15:0] vector_base_out,
  output logic irq_suppress_out,
  output logic [7:0] ext_irq_req_out,
  output logic wake_out,
  output logic io_clk_enable_out
);
  import irqv_pkg::*;

  typedef struct packed {
    logic select;
    logic unlock;
    logic [2:0] unlock_cnt;
    logic hold_insn;
    logic suppress;
    irqv_word_t base;
    irqv_byte_t rdata;
    irqv_pd_e pd;
    irqv_word_t su_cnt;
    logic wake;
    logic io_clk_en;
  } irqv_ctrl_s;

  irqv_ctrl_s s;
  irqv_ctrl_s next_s;
  logic wr_hit;
  logic rd_hit;
  logic lock_block;

  irqv_sense_if sif();

  // ----------------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------------
  function automatic logic reg_hit(input logic io_space, input irqv_byte_t addr);
    if (io_space) begin
      reg_hit = (addr == MVC_IO_OFFSET);
    end else begin
      reg_hit = (addr == MVC_DS_OFFSET);
    end
  endfunction

  function automatic irqv_byte_t reg_value(input logic select, input logic unlock);
    irqv_byte_t v;
    v = MVC_RESET;
    v[BIT_SELECT] = select;
    v[BIT_UNLOCK] = unlock;
    reg_value = v;
  endfunction

  assign wr_hit = wr_in && reg_hit(io_space_in, addr_in); // RULE_01
  assign rd_hit = rd_in && reg_hit(io_space_in, addr_in); // RULE_01

  // Running from the section that does not hold the vectors, under its lock.
  assign lock_block = (s.select && !exec_in_boot_in && app_side_boot_lock_in) || // RULE_08
                      (!s.select && exec_in_boot_in && boot_side_boot_lock_in);

  // ----------------------------------------------------------------------
  // Sense block hookup
  // ----------------------------------------------------------------------
  assign sif.sense_cfg = {ext_irq_sense_high_in, ext_irq_sense_low_in}; // RULE_10
  assign sif.enable = ext_irq_enable_in;
  assign sif.io_clk_run = s.io_clk_en; // RULE_13
  assign sif.powerdown = (s.pd == PD_ASLEEP);
  // Level requests wait until start-up is over.
  assign sif.level_mask = (s.pd != PD_AWAKE); // RULE_15
  assign sif.wdt_tick = wdt_tick_in;

  irqv_ext_sense u_sense (
    .clk_sys_in(clk_sys_in),
    .resetn_in(resetn_in),
    .ce_in(ce_in),
    .pins_in(ext_irq_pins_in),
    .sense(sif)
  );

  // ----------------------------------------------------------------------
  // Control state
  // ----------------------------------------------------------------------
  always_comb begin
    next_s = s;
    if (s.unlock) begin
      if (s.unlock_cnt == 3'h1) begin
        next_s.unlock = 1'b0; // RULE_07
        next_s.unlock_cnt = 3'h0;
      end else begin
        next_s.unlock_cnt = 3'(s.unlock_cnt - 3'h1);
      end
    end
    if (s.hold_insn && insn_end_in) begin
      next_s.hold_insn = 1'b0; // RULE_05
    end
    if (wr_hit) begin
      if (wdata_in[BIT_UNLOCK]) begin
        next_s.unlock = 1'b1;
        next_s.unlock_cnt = UNLOCK_CYCLES; // RULE_04
      end else if (s.unlock) begin
        next_s.select = wdata_in[BIT_SELECT]; // RULE_02
        next_s.unlock = 1'b0; // RULE_07
        next_s.unlock_cnt = 3'h0;
        next_s.hold_insn = 1'b1; // RULE_05
      end
      // Without a live unlock the select bit keeps its value.
    end
    // Only this output is raised; the core's global enable flag is left alone.
    next_s.suppress = next_s.unlock || next_s.hold_insn || lock_block; // RULE_06
    next_s.base = next_s.select ? BOOT_START[boot_size_fuses_in] : VECTOR_BASE_APP; // RULE_03
    next_s.rdata = rd_hit ? reg_value(s.select, s.unlock) : 8'h00;
    next_s.io_clk_en = !(sleep_in && !sleep_idle_in); // RULE_13
    next_s.wake = 1'b0;
    case (s.pd)
      PD_AWAKE: begin
        if (sleep_in && sleep_powerdown_in) begin
          next_s.pd = PD_ASLEEP;
        end else if (sleep_in && sif.wake) begin
          next_s.wake = 1'b1; // RULE_12
        end
      end
      PD_ASLEEP: begin
        if (sif.wake) begin
          next_s.pd = PD_STARTUP; // RULE_14
          next_s.su_cnt = 16'(STARTUP_CYC[startup_time_fuses_in] - 16'h0001);
        end
      end
      PD_STARTUP: begin
        if (s.su_cnt == 16'h0000) begin
          // Wake goes out even if the level has gone meanwhile.
          next_s.pd = PD_AWAKE; // RULE_15
          next_s.wake = 1'b1;
        end else begin
          next_s.su_cnt = 16'(s.su_cnt - 16'h0001);
        end
      end
      default: next_s.pd = PD_AWAKE;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      s <= '0;
      s.select <= MVC_RESET[BIT_SELECT];
      s.unlock <= MVC_RESET[BIT_UNLOCK];
      s.pd <= PD_AWAKE;
      s.io_clk_en <= 1'b1;
    end else if (ce_in) begin
      s <= next_s;
    end
  end

  assign rdata_out = s.rdata;
  assign vector_base_out = s.base;
  assign irq_suppress_out = s.suppress;
  assign ext_irq_req_out = sif.req;
  assign wake_out = s.wake;
  assign io_clk_enable_out = s.io_clk_en;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in || !ce_in);

  sequence unlock_wr;
    wr_hit && wdata_in[BIT_UNLOCK];
  endsequence

  sequence select_wr;
    wr_hit && !wdata_in[BIT_UNLOCK] && s.unlock;
  endsequence

  AST_REG_READ: assert property (rd_hit |=> (rdata_out[BIT_SELECT] == $past(s.select)) && // RULE_01
    (rdata_out[BIT_UNLOCK] == $past(s.unlock)))
    else $error("register read data wrong");
  AST_UNLOCK_FOUR: assert property ($rose(s.unlock) && !wr_hit ##1 !wr_hit [*3] // RULE_07
    |-> s.unlock ##1 !s.unlock)
    else $error("unlock did not last four cycles");
  AST_SELECT_TAKEN: assert property (select_wr |=> !s.unlock && // RULE_07
    (s.select == $past(wdata_in[BIT_SELECT])))
    else $error("select write not taken");
  AST_SELECT_GUARD: assert property (wr_hit && !s.unlock |=> s.select == $past(s.select)) // RULE_16
    else $error("select changed without unlock");
  AST_SUPPRESS_UNLOCK: assert property (unlock_wr |=> irq_suppress_out && s.unlock) // RULE_05
    else $error("no suppression after unlock");
  AST_SUPPRESS_HOLD: assert property (select_wr ##1 !insn_end_in |=> irq_suppress_out) // RULE_05
    else $error("suppression dropped before next instruction");
  AST_BASE_APP: assert property (!s.select |-> vector_base_out == VECTOR_BASE_APP) // RULE_02
    else $error("vector base not flash start");
  AST_BASE_BOOT: assert property (s.select && $stable(boot_size_fuses_in) && // RULE_03
    $past(s.select) |-> vector_base_out == BOOT_START[boot_size_fuses_in])
    else $error("vector base not boot start");
  AST_LOCK_BLOCK: assert property (lock_block |=> irq_suppress_out) // RULE_08
    else $error("boot lock did not block interrupts");
  AST_IOCLK_STOP: assert property (sleep_in && !sleep_idle_in |=> !io_clk_enable_out) // RULE_13
    else $error("io clock left running in deep sleep");
endmodule

// *** tb/irqv_pin_src.sv ***
`timescale 1ns/1ps
module irqv_pin_src (
  input wire logic [7:0] pull_low_in,
  output logic [7:0] pins_out
);
  // Pins are open drain with a pull-up, so a released pin reads high.
  assign pins_out = ~pull_low_in;
endmodule

// *** tb/irq_vector_and_external_irq_tb.sv ***
`timescale 1ns/1ps
module irq_vector_and_external_irq_tb;
  import irqv_pkg::*;
  localparam logic [3:0][15:0] BOOTS = {16'hE000, 16'hC000, 16'hA000, 16'h8000};
  localparam logic [3:0][15:0] SUTS = {16'h0010, 16'h000C, 16'h0008, 16'h0004};
  logic clk_sys_in = 1'h0;
  logic resetn_in = 1'h0;
  logic io_space = 1'h1, wr = 1'h0, rd = 1'h0, insn_end = 1'h0, exec_boot = 1'h0;
  logic app_lock = 1'h0, boot_lock = 1'h0, sleep = 1'h0, sleep_idle = 1'h0;
  logic sleep_pd = 1'h0, wdt_tick = 1'h0, supp, wake, ioclk;
  logic [1:0] bfuse = 2'h0, tfuse = 2'h0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, sense_lo = 8'h55, sense_hi = 8'h55;
  logic [7:0] en = 8'h00, low = 8'h00, pins, rdata, req;
  logic [15:0] vbase, cfg;
  int checks = 0, mismatches = 0, cycles = 0, hits, stray, waited, kk, wakes, want;
  int m_sel = 0, m_win = 0, m_hold = 0;
  logic ce = 1'h1, m_supp = 1'h0, m_hit, m_lock;
  logic [7:0] m_rd[$];

  irqv_pin_src i_src (.pull_low_in(low), .pins_out(pins));
  irqv_ctrl #(.BOOT_START(BOOTS), .STARTUP_CYC(SUTS)) i_dut (
    .clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .ce_in(ce), .io_space_in(io_space),
    .addr_in(addr), .wr_in(wr), .rd_in(rd), .wdata_in(wdata), .insn_end_in(insn_end),
    .boot_size_fuses_in(bfuse), .exec_in_boot_in(exec_boot), .app_side_boot_lock_in(app_lock),
    .boot_side_boot_lock_in(boot_lock), .sleep_in(sleep), .sleep_idle_in(sleep_idle),
    .sleep_powerdown_in(sleep_pd), .startup_time_fuses_in(tfuse), .wdt_tick_in(wdt_tick),
    .ext_irq_pins_in(pins), .ext_irq_sense_low_in(sense_lo), .ext_irq_sense_high_in(sense_hi),
    .ext_irq_enable_in(en), .rdata_out(rdata), .vector_base_out(vbase),
    .irq_suppress_out(supp), .ext_irq_req_out(req), .wake_out(wake), .io_clk_enable_out(ioclk));

  always #2.5 clk_sys_in = ~clk_sys_in;

  // ----------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      test_done();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // ----------------------------------------------------------------
  // Reference model of the control register, stepped between edges
  // ----------------------------------------------------------------
  always @(negedge clk_sys_in) begin
    if (!resetn_in) begin
      m_sel = 0;
      m_win = 0;
      m_hold = 0;
      m_supp = 1'h0;
      m_rd.delete();
    end else begin
      chk(vbase, m_sel[0] ? BOOTS[bfuse] : VECTOR_BASE_APP);
      chk(16'(supp), 16'(m_supp));
      if (m_rd.size() > 0) chk(16'(rdata), 16'(m_rd.pop_front()));
      if (ce) begin
        m_hit = (wr || rd) && (addr == (io_space ? 8'h35 : 8'h55));
        m_lock = (m_sel == 1 && !exec_boot && app_lock) || (m_sel == 0 && exec_boot && boot_lock);
        if (rd) m_rd.push_back(m_hit ? 8'({m_sel[0], m_win > 0}) : 8'h00);
        if (m_hold != 0 && insn_end) m_hold = 0;
        if (wr && m_hit && wdata[0]) begin
          m_win = 4;
        end else if (wr && m_hit && m_win > 0) begin
          m_sel = int'(wdata[1]);
          m_win = 0;
          m_hold = 1;
        end else if (m_win > 0) begin
          m_win--;
        end
        m_supp = (m_win > 0) || (m_hold != 0) || m_lock;
      end
    end
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask

  task automatic acc(input logic w, input logic ios, input logic [7:0] a, input logic [7:0] d);
    step(1);
    io_space = ios;
    addr = a;
    wdata = d;
    wr = w;
    rd = !w;
    step(1);
    wr = 1'h0;
    rd = 1'h0;
  endtask

  // Unlock, then select, then let one instruction end.
  task automatic move(input logic ios, input logic sel);
    acc(1'h1, ios, ios ? 8'h35 : 8'h55, 8'h01);
    chk(supp, 1'h1);
    acc(1'h1, ios, ios ? 8'h35 : 8'h55, {6'h00, sel, 1'h0});
    chk(vbase, sel ? BOOTS[bfuse] : VECTOR_BASE_APP);
    chk(supp, 1'h1);
    insn_end = 1'h1;
    step(1);
    insn_end = 1'h0;
    chk(supp, 1'h0);
    acc(1'h0, ios, ios ? 8'h35 : 8'h55, 8'h00);
    chk(rdata, {6'h00, sel, 1'h0});
  endtask

  task automatic tick();
    wdt_tick = 1'h1;
    step(1);
    wdt_tick = 1'h0;
    step(2);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(17));
    bfuse = 2'($urandom);
    tfuse = 2'($urandom);
    step(10);
    resetn_in = 1'h1;
    chk(vbase, VECTOR_BASE_APP);
    chk(16'({supp, wake, ioclk}), 16'h0001);
    chk(req, 8'h00);
    acc(1'h0, 1'h1, 8'h35, 8'h00);
    chk(rdata, MVC_RESET);
    acc(1'h1, 1'h0, 8'h56, 8'h01);
    acc(1'h0, 1'h1, 8'h36, 8'h00);
    chk({rdata, 7'h00, supp}, 16'h0000);
    acc(1'h1, 1'h1, 8'h35, 8'h02);
    chk(vbase, VECTOR_BASE_APP);
    acc(1'h1, 1'h1, 8'h35, 8'h01);
    step(3);
    chk(supp, 1'h1);
    step(1);
    chk(supp, 1'h0);
    acc(1'h1, 1'h1, 8'h35, 8'h02);
    acc(1'h0, 1'h0, 8'h55, 8'h00);
    chk(16'(rdata), 16'h0000);
    chk(vbase, VECTOR_BASE_APP);
    acc(1'h1, 1'h1, 8'h35, 8'h01);
    ce = 1'h0;
    step(8);
    chk(16'(supp), 16'h0001);
    ce = 1'h1;
    step(4);
    chk(16'(supp), 16'h0000);
    $display("test register_window done");
    move(1'h1, 1'h1);
    app_lock = 1'h1;
    step(2);
    chk(supp, 1'h1);
    exec_boot = 1'h1;
    step(2);
    chk(supp, 1'h0);
    app_lock = 1'h0;
    move(1'h0, 1'h0);
    boot_lock = 1'h1;
    step(2);
    chk(supp, 1'h1);
    exec_boot = 1'h0;
    step(2);
    chk(supp, 1'h0);
    boot_lock = 1'h0;
    $display("test vector_move done");
    for (int s = 0; s < 2; s++) begin
      sleep = s[0];
      for (int n = 0; n < 8; n++) begin
        for (int m = 0; m < 3; m++) begin
          cfg = 16'h5555;
          cfg[2*n+:2] = m == 0 ? SENSE_LOW : m == 1 ? SENSE_FALL : SENSE_RISE;
          {sense_hi, sense_lo} = cfg;
          en = 8'($urandom) | (8'h01 << n);
          step(3);
          chk(ioclk, !s[0]);
          hits = 0;
          stray = 0;
          wakes = 0;
          for (int c = 0; c < 16; c++) begin
            low = c < 8 ? 8'h01 << n : 8'h00;
            step(1);
            hits += int'(req[n]);
            stray += int'(|(req & ~(8'h01 << n)));
            wakes += int'(wake);
          end
          want = m == 0 ? 8 : (s == 1 && n >= 4) ? 0 : 1;
          chk(16'(hits), 16'(want));
          chk(16'(wakes), 16'(s == 1 ? want : 0));
          chk(16'(stray), 16'h0000);
        end
      end
    end
    sleep = 1'h0;
    $display("test pin_sensing done");
    {sense_hi, sense_lo} = 16'h5545;
    en = 8'h04;
    for (int k = 0; k < 3; k++) begin
      kk = (k + 1) % 3;
      sleep = 1'h1;
      sleep_pd = 1'h1;
      step(2);
      low = 8'h04;
      step(4);
      tick();
      if (kk > 0) tick();
      if (kk < 2) low = 8'h00;
      hits = 0;
      waited = 0;
      while (wake !== 1'h1 && waited < 40) begin
        step(1);
        waited++;
        hits += int'(req[2]);
      end
      chk(16'(waited < 40), 16'(kk > 0));
      if (kk > 0) chk(16'(waited >= int'(SUTS[tfuse]) - 2), 16'h0001);
      chk(16'(hits), 16'h0000);
      sleep = 1'h0;
      sleep_pd = 1'h0;
      step(2);
      if (kk > 0) chk(req[2], kk == 2);
      low = 8'h00;
      // Let a released level drain from the synchronisers before sleeping again.
      step(4);
    end
    $display("test powerdown_wake done");
    test_done();
  end
endmodule
